// *** pkg/svo_map.svh ***
// Constant map of the servo output and fail-safe controller
`ifndef SVO_MAP_SVH
`define SVO_MAP_SVH
`define SVO_OUTS 24
`define SVO_BANK_PINS 8
`define SVO_CHANS 16
`define SVO_POS_W 12
`define SVO_CFG_W 78
// Clock rate in MHz (125) and microsecond tick length in us
`define SVO_CLK_MHZ 7'h7D
`define SVO_TICK_US 7'h01
`define SVO_US_CYC (7'(`SVO_CLK_MHZ * `SVO_TICK_US))
// Microseconds per millisecond and milliseconds per second (1000)
`define SVO_MS_US 10'h3E8
`define SVO_S_MS 10'h3E8
// Receiver alarm after 1000 ms silence, link loss after 100 ms
`define SVO_RX_ALARM_MS 11'h3E8
`define SVO_LOSS_MS 11'h064
// Temperature alarm limit, 80 degrees Celsius
`define SVO_TEMP_LIMIT_C 8'sh50
// Pulse neutral 1500 us, group slot 2500 us, auto period fallback 20000 us
`define SVO_NEUTRAL_US 12'h5DC
`define SVO_GROUP_SLOT_US 12'h9C4
`define SVO_AUTO_MAX_US 16'h4E20
`define SVO_PCT_FULL 7'h64
// Statistic start values after a clear
`define SVO_VMIN_INIT 12'hFFF
`define SVO_TMIN_INIT 8'sh7F
`define SVO_TMAX_INIT 8'sh80
`endif

// *** pkg/svo_pkg.sv ***
// Types of the servo output and fail-safe controller
`include "svo_map.svh"
package svo_pkg;
  typedef enum logic [3:0] {
    SVO_IDLE = 4'b0001,
    SVO_CFG = 4'b0010,
    SVO_CHN = 4'b0100,
    SVO_CALC = 4'b1000
  } svo_fsm_t;
  // Loss behaviour: servo hold/off/preset, logic hold/low/high
  typedef enum logic [1:0] {
    SVO_LOSS_HOLD = 2'h0,
    SVO_LOSS_OFF_LOW = 2'h1,
    SVO_LOSS_PRESET_HIGH = 2'h2
  } svo_loss_t;
  typedef enum logic [1:0] {
    SVO_FMT_NONE = 2'h0,
    SVO_FMT_PULSE_POS = 2'h1,
    SVO_FMT_SERIAL = 2'h2,
    SVO_FMT_ALT_SERIAL = 2'h3
  } svo_fmt_t;
  typedef logic signed [`SVO_POS_W-1:0] svo_pos_t;
  typedef struct packed {
    logic [3:0] input_channel_select;
    logic reverse;
    logic logic_input;
    svo_pos_t trim;
    svo_pos_t upper_travel_limit;
    svo_pos_t lower_travel_limit;
    svo_pos_t loss_preset_position;
    svo_pos_t logic_threshold;
    logic [7:0] loss_transition_rate;
    logic [1:0] group;
    svo_loss_t loss_mode;
  } svo_out_cfg_t;
  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    svo_pos_t pos;
    logic frame_end;
    svo_fmt_t fmt;
  } svo_rx_t;
  typedef struct packed {
    logic [11:0] volt1;
    logic [11:0] volt2;
    logic [11:0] current;
    logic [15:0] capacity;
    logic signed [7:0] temp;
  } svo_meas_t;
  typedef struct packed {
    logic en_rx1;
    logic en_rx2;
    logic en_temp;
    logic en_volt1;
    logic en_volt2;
    logic en_current;
    logic en_capacity;
    logic en_overload;
    logic [11:0] volt1_thr;
    logic [11:0] volt2_thr;
    logic [11:0] current_thr;
    logic [15:0] capacity_thr;
  } svo_alarm_cfg_t;
  typedef struct packed {
    logic rx1;
    logic rx2;
    logic temp;
    logic volt1;
    logic volt2;
    logic current;
    logic capacity;
    logic overload;
  } svo_alarm_t;
  typedef struct packed {
    logic [11:0] vmin;
    logic [11:0] vmax;
    logic [11:0] imax;
    logic signed [7:0] tmin;
    logic signed [7:0] tmax;
    logic [1:0][15:0] present_s;
    logic [15:0] total_s;
    logic [1:0][6:0] present_pct;
    logic [1:0][1:0] format;
  } svo_stats_t;
  typedef struct packed {
    svo_fsm_t fsm;
    logic [4:0] idx;
    logic [6:0] us_div;
    logic [15:0] us;
    logic [9:0] ms_div;
    logic [9:0] s_div;
    logic [1:0][10:0] silent_ms;
    logic [15:0] loss_ms;
    logic lost;
    logic [`SVO_OUTS-1:0][`SVO_POS_W-1:0] cur;
    logic [`SVO_OUTS-1:0][11:0] width;
    logic [`SVO_OUTS-1:0][1:0] group;
    logic [`SVO_OUTS-1:0] pulse_en;
    logic [`SVO_OUTS-1:0] lvl;
    logic [`SVO_OUTS-1:0] dir_in;
    logic [`SVO_OUTS-1:0] pin_out;
    logic [`SVO_OUTS-1:0] in_state;
    logic [`SVO_OUTS-1:0] ovl;
    svo_alarm_t alarms;
    svo_stats_t stats;
  } svo_st_t;
endpackage : svo_pkg

// *** sim/svo_ctrl_asserts.sv ***
// Port-level assertions for the servo output controller
`timescale 1ns/1ps
`include "svo_map.svh"
module svo_ctrl_asserts import svo_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] bank_logic,
  input wire svo_rx_t primary_receiver_input,
  input wire svo_meas_t meas,
  input wire svo_alarm_cfg_t alarm_cfg,
  input wire logic [`SVO_OUTS-1:0] overload_in,
  input wire logic stats_clear,
  input wire logic [`SVO_OUTS-1:0] servo_pins_in,
  input wire logic [`SVO_OUTS-1:0] servo_pins_oe_n,
  input wire svo_alarm_t alarms,
  input wire svo_stats_t stats,
  input wire logic [`SVO_OUTS-1:0] input_state,
  input wire logic [`SVO_OUTS-1:0] overload_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [`SVO_OUTS-1:0] servo_mask;
  ////////////////////////////////////////////////////////////////////////
  // Pins of banks left in servo mode
  assign servo_mask = ~{{8{bank_logic[2]}}, {8{bank_logic[1]}}, {8{bank_logic[0]}}};
  a_servo_driven: assert property ((servo_pins_oe_n & servo_mask) == '0)
    else $error("servo bank pin released");
  a_input_seen: assert property (!$past(rst) && $stable(servo_pins_oe_n)
    |-> input_state == ($past(servo_pins_in) & $past(servo_pins_oe_n)))
    else $error("input state wrong");
  ////////////////////////////////////////////////////////////////////////
  // Overload flags and alarms, one register stage each
  a_ovl_copy: assert property (!$past(rst) |-> overload_flags == $past(overload_in))
    else $error("overload flags wrong");
  a_ovl_alarm: assert property (!$past(rst)
    |-> alarms.overload == ($past(alarm_cfg.en_overload) && (|$past(overload_flags))))
    else $error("overload alarm wrong");
  a_temp_alarm: assert property (!$past(rst)
    |-> alarms.temp == ($past(alarm_cfg.en_temp) && ($past(meas.temp) > `SVO_TEMP_LIMIT_C)))
    else $error("temperature alarm wrong");
  a_volt_alarm: assert property (!$past(rst)
    |-> alarms.volt1 == ($past(alarm_cfg.en_volt1) && ($past(meas.volt1) < $past(alarm_cfg.volt1_thr))))
    else $error("voltage alarm wrong");
  a_curr_alarm: assert property (!$past(rst)
    |-> alarms.current == ($past(alarm_cfg.en_current) && ($past(meas.current) > $past(alarm_cfg.current_thr))))
    else $error("current alarm wrong");
  a_cap_alarm: assert property (!$past(rst)
    |-> alarms.capacity == ($past(alarm_cfg.en_capacity) && ($past(meas.capacity) >= $past(alarm_cfg.capacity_thr))))
    else $error("capacity alarm wrong");
  a_rx2_off: assert property (!$past(rst) && !$past(alarm_cfg.en_rx2) |-> !alarms.rx2)
    else $error("disabled alarm raised");
  ////////////////////////////////////////////////////////////////////////
  // Statistics tracking
  a_imax_hold: assert property (!$past(rst) && !$past(stats_clear)
    |-> stats.imax >= $past(stats.imax) && stats.imax >= $past(meas.current))
    else $error("current maximum lost");
  a_fmt_seen: assert property (!$past(rst) && $past(primary_receiver_input.valid)
    |-> stats.format[0] == $past(primary_receiver_input.fmt))
    else $error("format not reported");
endmodule : svo_ctrl_asserts

bind svo_ctrl svo_ctrl_asserts u_chk (
  .clk(clk), .rst(rst), .bank_logic(bank_logic), .primary_receiver_input(primary_receiver_input),
  .meas(meas), .alarm_cfg(alarm_cfg), .overload_in(overload_in), .stats_clear(stats_clear),
  .servo_pins_in(servo_pins_in), .servo_pins_oe_n(servo_pins_oe_n), .alarms(alarms),
  .stats(stats), .input_state(input_state), .overload_flags(overload_flags)
);

// *** sim/svo_ctrl_tb.sv ***
// Self-checking bench for the servo output controller
`timescale 1ns/1ps
`include "svo_map.svh"
module svo_ctrl_tb import svo_pkg::*; ;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cfg_we = 1'h0;
  logic [4:0] cfg_idx = 5'h00;
  svo_out_cfg_t cfg_data = '0;
  logic fs_enable = 1'h0;
  logic [15:0] loss_delay_ms = 16'h0000;
  logic [15:0] period_us = 16'h0004;
  logic [2:0] bank_logic = 3'h6;
  svo_rx_t primary_receiver_input;
  svo_rx_t secondary_receiver_input;
  svo_meas_t meas = {12'h7D0, 12'h7D0, 12'h064, 16'h0000, 8'h19};
  svo_alarm_cfg_t alarm_cfg = {8'h80, 12'h5DC, 12'h5DC, 12'h0C8, 16'h03E8};
  logic [23:0] overload_in = 24'h00_0000;
  logic stats_clear = 1'h0;
  logic [23:0] pin_gnd = 24'h00_0000;
  logic [23:0] servo_pins_in;
  logic [23:0] servo_pins_out;
  logic [23:0] servo_pins_oe_n;
  svo_alarm_t alarms;
  svo_stats_t stats;
  logic [23:0] input_state;
  logic [23:0] overload_flags;
  logic signal_lost;
  int error_cnt = 0;
  int check_count = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock, wire levels with pull-ups on released pins, parts
  always #4 clk = ~clk;
  assign servo_pins_in = (servo_pins_out & ~servo_pins_oe_n) | (servo_pins_oe_n & ~pin_gnd);
  svo_rx_model rx1 (.clk(clk), .rx(primary_receiver_input));
  svo_rx_model rx2 (.clk(clk), .rx(secondary_receiver_input));
  svo_ctrl dut (
    .clk(clk), .rst(rst), .cfg_we(cfg_we), .cfg_idx(cfg_idx), .cfg_data(cfg_data),
    .fs_enable(fs_enable), .loss_delay_ms(loss_delay_ms), .period_us(period_us),
    .bank_logic(bank_logic), .primary_receiver_input(primary_receiver_input),
    .secondary_receiver_input(secondary_receiver_input), .meas(meas), .alarm_cfg(alarm_cfg),
    .overload_in(overload_in), .stats_clear(stats_clear), .servo_pins_in(servo_pins_in),
    .servo_pins_out(servo_pins_out), .servo_pins_oe_n(servo_pins_oe_n), .alarms(alarms),
    .stats(stats), .input_state(input_state), .overload_flags(overload_flags),
    .signal_lost(signal_lost)
  );
  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // One configuration word per output, threshold and loss mode chosen
  task automatic cfg(input logic [4:0] i, input logic [3:0] ch, input logic rv, input logic li,
      input svo_pos_t thr, input logic [1:0] g, input svo_loss_t m);
    step(1);
    cfg_we = 1'h1;
    cfg_idx = i;
    cfg_data = '{ch, rv, li, 12'sh000, 12'sh7FF, 12'sh800, 12'sh000, thr, 8'h00, g, m};
    step(1);
    cfg_we = 1'h0;
  endtask : cfg
  task automatic wait_link();
    for (int n = 0; n < 50 && signal_lost !== 1'h0; n++) step(1);
    if (signal_lost !== 1'h0) begin
      error_cnt++;
      $display("[ERR] %0t link never recovered", $time);
      stop_test();
    end
  endtask : wait_link
  task automatic alm(input logic [7:0] exp, input string what);
    step(3);
    chk(alarms, exp, what);
  endtask : alm
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    step(5);
    rst = 1'h0;
    step(2);
    chk(alarms.rx1, 1'h1, "rx1 alarm");
    chk(alarms.rx2, 1'h0, "rx2 alarm off");
    chk(signal_lost, 1'h1, "lost after reset");
    for (int i = 0; i < 24; i++) cfg(5'(i), 4'h0, 1'h0, 1'h0, 12'sh000, 2'h0, SVO_LOSS_OFF_LOW);
    cfg(5'h00, 4'h0, 1'h0, 1'h0, 12'sh000, 2'h0, SVO_LOSS_HOLD);
    cfg(5'h02, 4'h0, 1'h0, 1'h0, 12'sh000, 2'h0, SVO_LOSS_PRESET_HIGH);
    cfg(5'h03, 4'h0, 1'h0, 1'h0, 12'sh000, 2'h1, SVO_LOSS_HOLD);
    cfg(5'h04, 4'h0, 1'h0, 1'h1, 12'sh000, 2'h0, SVO_LOSS_OFF_LOW);
    cfg(5'h08, 4'h0, 1'h0, 1'h1, 12'sh000, 2'h0, SVO_LOSS_OFF_LOW);
    cfg(5'h09, 4'h0, 1'h0, 1'h1, 12'sh000, 2'h0, SVO_LOSS_OFF_LOW);
    cfg(5'h11, 4'h1, 1'h0, 1'h0, 12'sh000, 2'h0, SVO_LOSS_PRESET_HIGH);
    cfg(5'h12, 4'h0, 1'h1, 1'h0, 12'sh000, 2'h0, SVO_LOSS_OFF_LOW);
    cfg(5'h13, 4'h0, 1'h0, 1'h0, 12'sh064, 2'h0, SVO_LOSS_OFF_LOW);
    cfg(5'h14, 4'h0, 1'h0, 1'h0, 12'sh065, 2'h0, SVO_LOSS_OFF_LOW);
    // Link lost since reset: fail-safe off, then on with zero delay
    step(1200);
    repeat (4) begin
      step(97);
      chk(servo_pins_out[3:0], 4'h0, "pulses with fail-safe off");
    end
    fs_enable = 1'h1;
    step(1200);
    repeat (4) begin
      step(97);
      chk(servo_pins_out[3:0], 4'h5, "servo loss modes");
      chk(servo_pins_out[20:16], 5'h02, "logic loss levels");
    end
    // Released pins read back, grounded or open
    for (int k = 0; k < 2; k++) begin
      pin_gnd = k ? 24'h00_0100 : 24'hFF_FEFF;
      step(3);
      chk(servo_pins_oe_n[9:8], 2'h3, "input pins released");
      chk(input_state, ~pin_gnd & 24'h00_0300, "input state");
    end
    chk({servo_pins_oe_n[16], servo_pins_oe_n[4]}, 2'h0, "driven pins");
    // Receivers come alive; the first frame only wakes the primary, the secondary is standby
    repeat (2) rx1.frame(12'sh064, 12'shF9C, SVO_FMT_SERIAL);
    wait_link();
    chk(stats.format[0], SVO_FMT_SERIAL, "rx1 format");
    chk(alarms.rx1, 1'h0, "rx1 alarm cleared");
    rx2.frame(12'shE0C, 12'shE0C, SVO_FMT_PULSE_POS);
    step(2);
    chk(stats.format[1], SVO_FMT_PULSE_POS, "rx2 format");
    step(1200);
    chk(servo_pins_out[20:16], 5'h09, "logic levels");
    chk(servo_pins_out[3:0], 4'h7, "group pulses");
    // Auto period: nothing moves until the frame mark
    period_us = 16'h0000;
    step(100);
    rx1.put(4'h0, 12'shED4, SVO_FMT_SERIAL, 1'h0);
    step(200);
    chk(servo_pins_out[18:16], 3'h1, "no pass before frame end");
    rx1.put(4'h0, 12'shED4, SVO_FMT_SERIAL, 1'h1);
    step(100);
    chk(servo_pins_out[18:16], 3'h4, "pass on frame end");
    // Alarm thresholds and off settings
    alarm_cfg.en_temp = 1'h1;
    meas.temp = 8'sh50;
    alm(8'h00, "temp at limit");
    meas.temp = 8'sh51;
    alm(8'h20, "temp above limit");
    alarm_cfg.en_temp = 1'h0;
    alm(8'h00, "temp alarm off");
    alarm_cfg[56:53] = 4'hF;
    meas = {12'h5DB, 12'h7D0, 12'h0C9, 16'h03E8, 8'h51};
    alm(8'h16, "supply alarms");
    meas = {12'h5DC, 12'h7D0, 12'h0C8, 16'h03E7, 8'h51};
    alm(8'h00, "supply alarms quiet");
    alarm_cfg.en_overload = 1'h1;
    overload_in = 24'h00_0020;
    alm(8'h01, "overload alarm");
    chk(overload_flags, 24'h00_0020, "overload flags");
    alarm_cfg.en_overload = 1'h0;
    alm(8'h00, "overload alarm off");
    // Extremes, then clear and track again
    chk({stats.vmin, stats.vmax, stats.imax}, 36'h5DB_7D0_0C9, "extremes");
    chk({stats.tmin, stats.tmax}, 16'h1951, "temperature extremes");
    meas = {12'h6A4, 12'h6A4, 12'h032, 16'h0000, 8'h1E};
    stats_clear = 1'h1;
    step(1);
    stats_clear = 1'h0;
    step(2);
    chk({stats.vmin, stats.vmax, stats.imax}, 36'h6A4_6A4_032, "extremes cleared");
    chk({stats.tmin, stats.tmax}, 16'h1E1E, "temperature cleared");
    stop_test();
  end
endmodule : svo_ctrl_tb

// *** sim/svo_rx_model.sv ***
// Receiver model that delivers channel positions and frame ends
`timescale 1ns/1ps
module svo_rx_model import svo_pkg::*; (
  input wire logic clk,
  output svo_rx_t rx
);
  initial rx = '0;
  // One word for one edge, then the data lines are scrambled
  task automatic put(input logic [3:0] ch, input svo_pos_t p, input svo_fmt_t f, input logic fe);
    @(posedge clk);
    #1;
    rx = '{!fe, ch, p, fe, f};
    @(posedge clk);
    #1;
    rx = '{1'h0, ~ch, ~p, 1'h0, f};
  endtask : put
  // Channels 0 and 1 followed by the frame mark
  task automatic frame(input svo_pos_t p0, input svo_pos_t p1, input svo_fmt_t f);
    put(4'h0, p0, f, 1'h0);
    put(4'h1, p1, f, 1'h0);
    put(4'h0, p0, f, 1'h1);
  endtask : frame
endmodule : svo_rx_model

// *** src/svo_ctrl.sv ***
// Servo output, logic pin, fail-safe, alarm and statistics controller
`timescale 1ns/1ps
`include "svo_map.svh"
module svo_ctrl import svo_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_we,
  input wire logic [4:0] cfg_idx,
  input wire svo_out_cfg_t cfg_data,
  input wire logic fs_enable,
  input wire logic [15:0] loss_delay_ms,
  input wire logic [15:0] period_us,
  input wire logic [2:0] bank_logic,
  input wire svo_rx_t primary_receiver_input,
  input wire svo_rx_t secondary_receiver_input,
  input wire svo_meas_t meas,
  input wire svo_alarm_cfg_t alarm_cfg,
  input wire logic [`SVO_OUTS-1:0] overload_in,
  input wire logic stats_clear,
  input wire logic [`SVO_OUTS-1:0] servo_pins_in,
  output logic [`SVO_OUTS-1:0] servo_pins_out,
  output logic [`SVO_OUTS-1:0] servo_pins_oe_n,
  output svo_alarm_t alarms,
  output svo_stats_t stats,
  output logic [`SVO_OUTS-1:0] input_state,
  output logic [`SVO_OUTS-1:0] overload_flags,
  output logic signal_lost
);
  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Clamp a wide signed value to the position range
  function automatic svo_pos_t svo_sat(input logic signed [13:0] v);
    svo_sat = (v > 14'sh07FF) ? 12'sh7FF : (v < -14'sh0800) ? -12'sh800 : svo_pos_t'(v);
  endfunction : svo_sat

  // Reverse, trim and travel clamp of one channel position
  function automatic svo_pos_t svo_shape(input svo_pos_t p, input svo_out_cfg_t c);
    svo_pos_t m;
    svo_pos_t t;
    m = c.reverse ? svo_sat(-14'(p)) : p;
    t = svo_sat(14'(m) + 14'(c.trim));
    if (t > c.upper_travel_limit) begin
      t = c.upper_travel_limit;
    end else if (t < c.lower_travel_limit) begin
      t = c.lower_travel_limit;
    end
    svo_shape = t;
  endfunction : svo_shape

  // Step toward the preset by at most the rate; rate zero jumps at once
  function automatic svo_pos_t svo_slew(input svo_pos_t cur, input svo_pos_t tgt, input logic [7:0] rate);
    logic signed [13:0] d;
    logic signed [13:0] r;
    d = 14'(tgt) - 14'(cur);
    r = 14'($signed({1'b0, rate}));
    if (rate == 8'h00 || (d <= r && d >= -r)) begin
      svo_slew = tgt;
    end else if (d > r) begin
      svo_slew = svo_sat(14'(cur) + r);
    end else begin
      svo_slew = svo_sat(14'(cur) - r);
    end
  endfunction : svo_slew

  // Present time as a percentage of total time
  function automatic logic [6:0] svo_pct(input logic [15:0] part, input logic [15:0] total);
    logic [22:0] num;
    num = 23'(part) * 23'(`SVO_PCT_FULL);
    svo_pct = (total == 16'h0000) ? 7'h00 : 7'(num / 23'(total));
  endfunction : svo_pct

  // Bank of a pin index: 0 for pins 1-8, 1 for 9-16, 2 for 17-24
  function automatic logic [1:0] svo_bank(input int i);
    svo_bank = 2'(i / `SVO_BANK_PINS);
  endfunction : svo_bank

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and channel memories

  svo_st_t st;
  svo_st_t next_st;
  svo_out_cfg_t cfg_rd;
  logic [`SVO_CFG_W-1:0] cfg_raw;
  svo_pos_t chan_rd;
  svo_rx_t act;
  logic pri_alive;
  logic chan_we;

  // Primary receiver wins while alive, else secondary
  assign pri_alive = st.silent_ms[0] < `SVO_LOSS_MS;
  assign act = pri_alive ? primary_receiver_input : secondary_receiver_input;
  assign chan_we = act.valid;
  assign cfg_rd = svo_out_cfg_t'(cfg_raw);

  svo_mem #(.W(`SVO_CFG_W), .D(`SVO_OUTS), .AW(5)) u_cfg_mem (
    .clk(clk),
    .we(cfg_we),
    .wr_addr(cfg_idx),
    .wr_data(cfg_data),
    .rd_addr(st.idx),
    .rd_data(cfg_raw)
  );

  svo_mem #(.W(`SVO_POS_W), .D(`SVO_CHANS), .AW(4)) u_chan_mem (
    .clk(clk),
    .we(chan_we),
    .wr_addr(act.chan),
    .wr_data(act.pos),
    .rd_addr(cfg_rd.input_channel_select),
    .rd_data(chan_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic us_tick;
    logic ms_tick;
    logic s_tick;
    logic start;
    logic fs_phase;
    logic [1:0] bank;
    logic [15:0] gstart;
    logic [15:0] gend;
    svo_pos_t p;
    svo_pos_t rv;
    svo_rx_t rx;
    us_tick = 1'b0;
    ms_tick = 1'b0;
    s_tick = 1'b0;
    start = 1'b0;
    fs_phase = 1'b0;
    bank = 2'h0;
    gstart = 16'h0000;
    gend = 16'h0000;
    p = '0;
    rv = '0;
    rx = '0;
    next_st = st;

    // Microsecond, millisecond and second enables
    if (st.us_div == `SVO_US_CYC - 7'h01) begin
      next_st.us_div = 7'h00;
      us_tick = 1'b1;
    end else begin
      next_st.us_div = st.us_div + 7'h01;
    end
    if (us_tick) begin
      next_st.ms_div = (st.ms_div == `SVO_MS_US - 10'h001) ? 10'h000 : st.ms_div + 10'h001;
      ms_tick = st.ms_div == `SVO_MS_US - 10'h001;
    end
    if (ms_tick) begin
      next_st.s_div = (st.s_div == `SVO_S_MS - 10'h001) ? 10'h000 : st.s_div + 10'h001;
      s_tick = st.s_div == `SVO_S_MS - 10'h001;
    end

    // Receiver silence, format and link time statistics
    for (int r = 0; r < 2; r++) begin
      rx = (r == 0) ? primary_receiver_input : secondary_receiver_input;
      if (rx.valid) begin
        next_st.silent_ms[r] = 11'h000;
        next_st.stats.format[r] = rx.fmt;
      end else if (ms_tick && st.silent_ms[r] != 11'h7FF) begin
        next_st.silent_ms[r] = st.silent_ms[r] + 11'h001;
      end
      // A frame that ends a long silence reports its own format at once
      if (!rx.valid && st.silent_ms[r] > `SVO_RX_ALARM_MS) begin
        next_st.stats.format[r] = SVO_FMT_NONE;
      end
      if (s_tick && st.silent_ms[r] < `SVO_LOSS_MS) begin
        next_st.stats.present_s[r] = st.stats.present_s[r] + 16'h0001;
      end
      next_st.stats.present_pct[r] = svo_pct(st.stats.present_s[r], st.stats.total_s);
    end
    if (s_tick) begin
      next_st.stats.total_s = st.stats.total_s + 16'h0001;
    end

    // Link loss and loss delay timing
    next_st.lost = (st.silent_ms[0] >= `SVO_LOSS_MS) && (st.silent_ms[1] >= `SVO_LOSS_MS);
    if (!st.lost) begin
      next_st.loss_ms = 16'h0000;
    end else if (ms_tick && st.loss_ms != 16'hFFFF) begin
      next_st.loss_ms = st.loss_ms + 16'h0001;
    end
    fs_phase = st.lost && (st.loss_ms >= loss_delay_ms);

    // Output period: fixed, or restarted by each frame end of the active receiver while the link is up
    if (period_us != 16'h0000) begin
      start = us_tick && (st.us >= period_us - 16'h0001);
    end else begin
      start = (act.frame_end && !st.lost) || (us_tick && st.us >= `SVO_AUTO_MAX_US);
    end
    if (start) begin
      next_st.us = 16'h0000;
    end else if (us_tick && st.us != 16'hFFFF) begin
      next_st.us = st.us + 16'h0001;
    end

    // One pass over all outputs per period
    case (st.fsm)
      SVO_IDLE: begin
        next_st.idx = 5'h00;
        if (start) begin
          next_st.fsm = SVO_CFG;
        end
      end
      SVO_CFG: begin
        next_st.fsm = SVO_CHN;
      end
      SVO_CHN: begin
        next_st.fsm = SVO_CALC;
      end
      SVO_CALC: begin
        p = svo_shape(chan_rd, cfg_rd);
        rv = cfg_rd.reverse ? svo_sat(-14'(chan_rd)) : chan_rd;
        next_st.group[st.idx] = cfg_rd.group;
        next_st.dir_in[st.idx] = cfg_rd.logic_input;
        next_st.pulse_en[st.idx] = 1'b1;
        next_st.cur[st.idx] = p;
        next_st.lvl[st.idx] = !(rv < cfg_rd.logic_threshold);
        if (st.lost && !fs_enable) begin
          next_st.pulse_en[st.idx] = 1'b0;
        end
        if (st.lost) begin
          next_st.cur[st.idx] = st.cur[st.idx];
          next_st.lvl[st.idx] = st.lvl[st.idx];
        end
        if (fs_phase && fs_enable) begin
          case (cfg_rd.loss_mode)
            SVO_LOSS_OFF_LOW: begin
              next_st.pulse_en[st.idx] = 1'b0;
              next_st.lvl[st.idx] = 1'b0;
            end
            SVO_LOSS_PRESET_HIGH: begin
              next_st.cur[st.idx] = svo_slew(st.cur[st.idx], cfg_rd.loss_preset_position,
                                             cfg_rd.loss_transition_rate);
              next_st.lvl[st.idx] = 1'b1;
            end
            default: begin
              next_st.cur[st.idx] = st.cur[st.idx];
            end
          endcase
        end
        next_st.width[st.idx] = 12'(`SVO_NEUTRAL_US + 12'($signed(next_st.cur[st.idx]) >>> 1));
        if (st.idx == 5'(`SVO_OUTS - 1)) begin
          next_st.fsm = SVO_IDLE;
        end else begin
          next_st.idx = st.idx + 5'h01;
          next_st.fsm = SVO_CFG;
        end
      end
      default: begin
        next_st.fsm = SVO_IDLE;
      end
    endcase

    // Pin drive: banks choose servo pulses or logic levels
    for (int i = 0; i < `SVO_OUTS; i++) begin
      bank = svo_bank(i);
      gstart = 16'(st.group[i]) * 16'(`SVO_GROUP_SLOT_US);
      gend = gstart + 16'(st.width[i]);
      if (bank_logic[bank]) begin
        next_st.pin_out[i] = st.lvl[i] && !st.dir_in[i];
      end else begin
        next_st.pin_out[i] = st.pulse_en[i] && (st.us >= gstart) && (st.us < gend);
      end
      next_st.in_state[i] = bank_logic[bank] && st.dir_in[i] && servo_pins_in[i];
    end

    // Alarms, each gated by its own enable
    next_st.ovl = overload_in;
    next_st.alarms.rx1 = alarm_cfg.en_rx1 && (st.silent_ms[0] > `SVO_RX_ALARM_MS);
    next_st.alarms.rx2 = alarm_cfg.en_rx2 && (st.silent_ms[1] > `SVO_RX_ALARM_MS);
    next_st.alarms.temp = alarm_cfg.en_temp && (meas.temp > `SVO_TEMP_LIMIT_C);
    next_st.alarms.volt1 = alarm_cfg.en_volt1 && (meas.volt1 < alarm_cfg.volt1_thr);
    next_st.alarms.volt2 = alarm_cfg.en_volt2 && (meas.volt2 < alarm_cfg.volt2_thr);
    next_st.alarms.current = alarm_cfg.en_current && (meas.current > alarm_cfg.current_thr);
    next_st.alarms.capacity = alarm_cfg.en_capacity && (meas.capacity >= alarm_cfg.capacity_thr);
    next_st.alarms.overload = alarm_cfg.en_overload && (|st.ovl);

    // Extreme value tracking with explicit clear
    if (stats_clear) begin
      next_st.stats.vmin = `SVO_VMIN_INIT;
      next_st.stats.vmax = 12'h000;
      next_st.stats.imax = 12'h000;
      next_st.stats.tmin = `SVO_TMIN_INIT;
      next_st.stats.tmax = `SVO_TMAX_INIT;
    end else begin
      if (meas.volt1 < st.stats.vmin) next_st.stats.vmin = meas.volt1;
      if (meas.volt2 < next_st.stats.vmin) next_st.stats.vmin = meas.volt2;
      if (meas.volt1 > st.stats.vmax) next_st.stats.vmax = meas.volt1;
      if (meas.volt2 > next_st.stats.vmax) next_st.stats.vmax = meas.volt2;
      if (meas.current > st.stats.imax) next_st.stats.imax = meas.current;
      if (meas.temp < st.stats.tmin) next_st.stats.tmin = meas.temp;
      if (meas.temp > st.stats.tmax) next_st.stats.tmax = meas.temp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.fsm <= SVO_IDLE;
      st.silent_ms <= {2{11'h7FF}};
      st.lost <= 1'b1;
      st.stats.vmin <= `SVO_VMIN_INIT;
      st.stats.tmin <= `SVO_TMIN_INIT;
      st.stats.tmax <= `SVO_TMAX_INIT;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Drive pins unless the bank is logic and the pin is a pulled-up input
  always_comb begin
    for (int i = 0; i < `SVO_OUTS; i++) begin
      servo_pins_oe_n[i] = bank_logic[svo_bank(i)] && st.dir_in[i];
    end
  end
  assign servo_pins_out = st.pin_out;
  assign alarms = st.alarms;
  assign stats = st.stats;
  assign input_state = st.in_state;
  assign overload_flags = st.ovl;
  assign signal_lost = st.lost;
endmodule : svo_ctrl

// *** src/svo_mem.sv ***
// Small word memory with registered read data
`timescale 1ns/1ps
module svo_mem #(
  parameter int W = 12,
  parameter int D = 16,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [D];

  // Write port and registered read port; array has no reset
  always_ff @(posedge clk) begin
    if (we) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : svo_mem
